// [rtl/alarm_monitor.sv]
// Alarm monitor: sticky alarm flags, mask, summary, status pin, APB regs.
// Assumes alarm inputs are asynchronous to mclk_i, clocks to compare
// are already sampled by the device clock, APB on mclk_i.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Watch six internal alarm sources
// - Each alarm sets its own flag
// - Flags stick until host writes one
// - Unmasked alarms feed the summary indication
// - Pin goes high on alarm when selected
// - Channel clock mismatch per half-rate cycle flags
// - Clock upset flag held until written one
// - Upset FIFO pointers set lane error flag
// - Link enable toggle resets lane FIFO logic
// - Link disabled holds link block in reset
module alarm_monitor
  import alarm_pkg::*;
(
  input wire logic mclk_i, // Device clock, 250 MHz
  input wire logic rstn_i, // Async reset, active low
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic cpll_unlock_i, // Converter PLL not locked
  input wire logic spll_unlock_i, // Serdes PLL not locked
  input wire logic link_not_data_i, // Link not in data state
  input wire logic realign_i, // Reference pulse realigned clocks
  input wire logic [3:0] chan_a_clk_i, // Channel A internal clock phases
  input wire logic [3:0] chan_b_clk_i, // Channel B internal clock phases
  input wire logic [NUM_LANES-1:0] fifo_upset_i, // Per-lane pointer upset
  output logic link_enable_o, // High lets the link block run
  output logic link_rst_n_o, // Low holds link block and FIFOs in reset
  output logic serializer_pwrdn_o, // High powers serializers down
  output logic link_clk_gate_o, // High gates link clocks on
  output logic status_output_pin_o, // Alarm pin, high active
  output logic summary_alarm_o, // Masked summary indication
  output logic irq_o // Level interrupt
);

  // Two-flop synchronisers for the asynchronous alarm sources
  localparam int SYNC_W = 4 + NUM_LANES;
  logic [SYNC_W-1:0] sync1_q, sync2_q;
  logic [NUM_ALM-1:0] alarm_event_flags_q, alarm_event_flags_d;
  logic [NUM_ALM-1:0] alarm_type_mask_q;
  logic [NUM_LANES-1:0] lane_fifo_error_flags_q, lane_fifo_error_flags_d;
  logic [1:0] ctrl_q;
  logic summary_q; // Registered summary
  logic half_q; // Half-rate device clock enable
  logic mismatch_q; // Mismatch seen in current half-rate cycle
  logic [NUM_ALM-1:0] irq_st_q, irq_en_q;
  logic [SYNC_W-1:0] src_sync;

  // Synchroniser; only the second stage is read by logic
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {fifo_upset_i, realign_i, link_not_data_i,
                  spll_unlock_i, cpll_unlock_i};
      sync2_q <= sync1_q;
    end
  end
  assign src_sync = sync2_q;

  // Bus decode
  wire access_w = psel_i & penable_i;
  wire wr_w = access_w & pwrite_i;
  wire hit_flags = paddr_i == OFS_FLAGS;
  wire hit_mask = paddr_i == OFS_MASK;
  wire hit_ctrl = paddr_i == OFS_CTRL;
  wire hit_sum = paddr_i == OFS_SUMMARY;
  wire hit_lane = paddr_i == OFS_LANE;
  wire hit_ien = paddr_i == OFS_IRQ_EN;
  wire hit_iclr = paddr_i == OFS_IRQ_CLR;
  wire hit_ist = paddr_i == OFS_IRQ_ST;
  wire mapped_w = hit_flags | hit_mask | hit_ctrl | hit_sum | hit_lane |
                  hit_ien | hit_iclr | hit_ist;
  assign pready_o = 1'b1; // Zero-wait access phase
  assign pslverr_o = access_w & ~mapped_w;

  // Link enable drives reset, power and clock gating of the link block
  wire link_en_w = ctrl_q[CTRL_LINK_EN];
  assign link_enable_o = link_en_w;
  assign link_rst_n_o = link_en_w;
  assign serializer_pwrdn_o = ~link_en_w;
  assign link_clk_gate_o = link_en_w;

  // Half-rate clock comparison; any mismatch inside the window counts
  wire clk_diff_w = |(chan_a_clk_i ^ chan_b_clk_i);
  wire upset_w = half_q & (mismatch_q | clk_diff_w);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      half_q <= 1'b0;
      mismatch_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
      mismatch_q <= half_q ? 1'b0 : clk_diff_w;
    end
  end

  // Lane FIFO errors only count while the FIFO logic is out of reset
  wire [NUM_LANES-1:0] lane_ev_w = src_sync[SYNC_W-1:4] &
                                  {NUM_LANES{link_en_w}};
  wire [NUM_ALM-1:0] alarm_ev_w;
  assign alarm_ev_w[BIT_CPLL] = src_sync[0];
  assign alarm_ev_w[BIT_SPLL] = src_sync[1];
  assign alarm_ev_w[BIT_LINK] = src_sync[2];
  assign alarm_ev_w[BIT_REALIGN] = src_sync[3];
  assign alarm_ev_w[BIT_CLK_UPSET] = upset_w;
  assign alarm_ev_w[BIT_FIFO] = |lane_ev_w;

  // Sticky flags: set wins over the write-one clear
  wire [NUM_ALM-1:0] flag_clr_w = (wr_w & hit_flags) ?
                                  pwdata_i[NUM_ALM-1:0] : '0;
  wire [NUM_LANES-1:0] lane_clr_w = (wr_w & hit_lane) ?
                                    pwdata_i[NUM_LANES-1:0] : '0;
  always_comb begin
    alarm_event_flags_d = (alarm_event_flags_q & ~flag_clr_w)
                          | alarm_ev_w;
    lane_fifo_error_flags_d = (lane_fifo_error_flags_q & ~lane_clr_w)
                              | lane_ev_w;
  end

  // Interrupt status uses the same layout as the alarm flags
  wire [NUM_ALM-1:0] iclr_w = (wr_w & hit_iclr) ?
                              pwdata_i[NUM_ALM-1:0] : '0;

  // Register state
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alarm_event_flags_q <= '0;
      lane_fifo_error_flags_q <= '0;
      alarm_type_mask_q <= MASK_RST;
      ctrl_q <= CTRL_RST;
      summary_q <= 1'b0;
      irq_st_q <= '0;
      irq_en_q <= '0;
    end else begin
      alarm_event_flags_q <= alarm_event_flags_d;
      lane_fifo_error_flags_q <= lane_fifo_error_flags_d;
      irq_st_q <= (irq_st_q & ~iclr_w) | alarm_ev_w;
      // Summary follows flags one cycle later
      summary_q <= |(alarm_event_flags_q &
                     ~alarm_type_mask_q);
      if (wr_w & hit_mask) begin
        alarm_type_mask_q <= pwdata_i[NUM_ALM-1:0];
      end
      if (wr_w & hit_ctrl) begin
        ctrl_q <= pwdata_i[1:0];
      end
      if (wr_w & hit_ien) begin
        irq_en_q <= pwdata_i[NUM_ALM-1:0];
      end
    end
  end

  assign summary_alarm_o = summary_q;
  // Pin shows the summary only when selected as alarm output
  assign status_output_pin_o = ctrl_q[CTRL_PIN_SEL] & summary_q;
  assign irq_o = |(irq_st_q & irq_en_q);

  // Read mux, combinational from registers
  always_comb begin
    prdata_o = '0;
    if (hit_flags) prdata_o[NUM_ALM-1:0] = alarm_event_flags_q;
    if (hit_mask) prdata_o[NUM_ALM-1:0] = alarm_type_mask_q;
    if (hit_ctrl) prdata_o[1:0] = ctrl_q;
    if (hit_sum) prdata_o[0] = summary_q;
    if (hit_lane) prdata_o[NUM_LANES-1:0] = lane_fifo_error_flags_q;
    if (hit_ien) prdata_o[NUM_ALM-1:0] = irq_en_q;
    if (hit_ist) prdata_o[NUM_ALM-1:0] = irq_st_q;
  end

  // Checks
  property p_sticky;
    @(posedge mclk_i) disable iff (!rstn_i)
    alarm_event_flags_q[BIT_CPLL] && !flag_clr_w[BIT_CPLL]
      |=> alarm_event_flags_q[BIT_CPLL];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_clk_hold;
    @(posedge mclk_i) disable iff (!rstn_i)
    alarm_event_flags_q[BIT_CLK_UPSET] && !(wr_w && hit_flags)
      |=> alarm_event_flags_q[BIT_CLK_UPSET];
  endproperty
  a_clk_hold: assert property (p_clk_hold)
    else $error("clk flag lost");
  property p_upset;
    @(posedge mclk_i) disable iff (!rstn_i)
    half_q && clk_diff_w |=> alarm_event_flags_q[BIT_CLK_UPSET];
  endproperty
  a_upset: assert property (p_upset) else $error("upset missed");
  property p_set;
    @(posedge mclk_i) disable iff (!rstn_i)
    src_sync[0] |=> alarm_event_flags_q[BIT_CPLL];
  endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_summary;
    @(posedge mclk_i) disable iff (!rstn_i)
    1'b1 |=> summary_q == |($past(alarm_event_flags_q)
                              & ~$past(alarm_type_mask_q));
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary bad");
  property p_masked;
    @(posedge mclk_i) disable iff (!rstn_i)
    (alarm_type_mask_q == MASK_RST) [*2] |-> !summary_q;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked shown");
  property p_pin;
    @(posedge mclk_i) disable iff (!rstn_i)
    status_output_pin_o |-> summary_q && ctrl_q[CTRL_PIN_SEL];
  endproperty
  a_pin: assert property (p_pin) else $error("pin bad");
  property p_lane;
    @(posedge mclk_i) disable iff (!rstn_i)
    lane_ev_w[0] |=> lane_fifo_error_flags_q[0]
                     && alarm_event_flags_q[BIT_FIFO];
  endproperty
  a_lane: assert property (p_lane) else $error("lane missed");
  property p_reset;
    @(posedge mclk_i) disable iff (!rstn_i)
    !link_en_w |-> !link_rst_n_o && serializer_pwrdn_o && !link_clk_gate_o;
  endproperty
  a_reset: assert property (p_reset)
    else $error("link not held");

  // Write-one clear drops a flag when no new event lands with it
  sequence s_clr_cpll;
    wr_w && hit_flags && pwdata_i[BIT_CPLL] && !alarm_ev_w[BIT_CPLL];
  endsequence
  property p_w1c;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_clr_cpll |=> !alarm_event_flags_q[BIT_CPLL];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("flag not cleared");

  // An event in the same cycle as its clear must win
  sequence s_set_and_clr;
    flag_clr_w[BIT_CPLL] && alarm_ev_w[BIT_CPLL];
  endsequence
  property p_set_wins;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_set_and_clr |=> alarm_event_flags_q[BIT_CPLL];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat event");

  // The synchronised realign source reaches its own flag bit
  property p_realign;
    @(posedge mclk_i) disable iff (!rstn_i)
    src_sync[3] |=> alarm_event_flags_q[BIT_REALIGN];
  endproperty
  a_realign: assert property (p_realign)
    else $error("realign flag missed");

  // Unmasked flag shows on the summary one cycle later
  sequence s_unmasked_spll;
    alarm_event_flags_q[BIT_SPLL] && !alarm_type_mask_q[BIT_SPLL];
  endsequence
  property p_unmasked;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_unmasked_spll |=> summary_q;
  endproperty
  a_unmasked: assert property (p_unmasked)
    else $error("unmasked not shown");

  // Pin must be up whenever summary is up and alarm output is chosen
  property p_pin_on;
    @(posedge mclk_i) disable iff (!rstn_i)
    ctrl_q[CTRL_PIN_SEL] && summary_q |-> status_output_pin_o;
  endproperty
  a_pin_on: assert property (p_pin_on)
    else $error("pin stuck low");

  // Mismatch in the first half of a window is not lost
  sequence s_early_diff;
    !half_q && clk_diff_w ##1 half_q;
  endsequence
  property p_early_diff;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_early_diff |=> alarm_event_flags_q[BIT_CLK_UPSET];
  endproperty
  a_early_diff: assert property (p_early_diff)
    else $error("early mismatch missed");

  // Lane flags stay until their own write-one clear
  property p_lane_hold;
    @(posedge mclk_i) disable iff (!rstn_i)
    lane_fifo_error_flags_q[7] && !lane_clr_w[7]
      |=> lane_fifo_error_flags_q[7];
  endproperty
  a_lane_hold: assert property (p_lane_hold)
    else $error("lane flag lost");

  // Enabled link runs: out of reset, powered and clocked
  property p_link_run;
    @(posedge mclk_i) disable iff (!rstn_i)
    link_en_w |-> link_rst_n_o && !serializer_pwrdn_o && link_clk_gate_o;
  endproperty
  a_link_run: assert property (p_link_run)
    else $error("link not released");

endmodule : alarm_monitor
`default_nettype wire

// [rtl/alarm_pkg.sv]
// Constants for the alarm monitoring block: register map, bit layout,
// reset values. Assumes a 32-bit APB slave on the device clock.
package alarm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_FLAGS = 8'h00; // Alarm event flags, W1C
  localparam logic [7:0] OFS_MASK = 8'h04; // Alarm type mask
  localparam logic [7:0] OFS_CTRL = 8'h08; // Link enable, pin select
  localparam logic [7:0] OFS_SUMMARY = 8'h0c; // Masked summary, RO
  localparam logic [7:0] OFS_LANE = 8'h10; // Lane FIFO error flags, W1C
  localparam logic [7:0] OFS_IRQ_EN = 8'h14; // Interrupt enable
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18; // Interrupt status clear, WO
  localparam logic [7:0] OFS_IRQ_ST = 8'h1c; // Interrupt status, RO
  // Alarm flag positions
  localparam int NUM_ALM = 6;
  localparam int BIT_CPLL = 0;
  localparam int BIT_SPLL = 1;
  localparam int BIT_LINK = 2;
  localparam int BIT_REALIGN = 3;
  localparam int BIT_CLK_UPSET = 4;
  localparam int BIT_FIFO = 5;
  localparam int NUM_LANES = 8;
  // Control fields
  localparam int CTRL_LINK_EN = 0;
  localparam int CTRL_PIN_SEL = 1;
  // Reset values
  localparam logic [NUM_ALM-1:0] MASK_RST = 6'h3f;
  localparam logic [1:0] CTRL_RST = 2'h0;
endpackage : alarm_pkg

// [sim/tb_top.sv]
// Self-checking bench for the alarm monitor: APB register access,
// sticky flags, mask, pin, clock upset, lane flags, interrupt.
// Assumes the design's APB answers with pready as in the hand-over.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import alarm_pkg::*;
  logic mclk_i = 0, rstn_i = 0; // Clock and active-low reset
  logic psel = 0, penable = 0, pwrite = 0; // APB request
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic [3:0] alm = 4'h0, ca = 4'h0, cb = 4'h0; // Alarm causes, clocks
  logic [7:0] fifo = 8'h00; // Per-lane upsets
  logic lnk, lrst_n, pwrdn, gate, pin, summ, irq;
  int fail_count = 0, n_compared = 0, cyc = 0;
  always #2 mclk_i = ~mclk_i; // 250 MHz
  alarm_monitor alarm_monitor_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cpll_unlock_i(alm[0]),
    .spll_unlock_i(alm[1]), .link_not_data_i(alm[2]),
    .realign_i(alm[3]), .chan_a_clk_i(ca), .chan_b_clk_i(cb),
    .fifo_upset_i(fifo), .link_enable_o(lnk), .link_rst_n_o(lrst_n),
    .serializer_pwrdn_o(pwrdn), .link_clk_gate_o(gate),
    .status_output_pin_o(pin), .summary_alarm_o(summ), .irq_o(irq));
  // Single place that prints the verdict and ends the run
  task automatic report_and_stop;
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Compare and count; x never matches thanks to case equality
  task automatic chk(input logic [31:0] s, input logic [31:0] e,
                     input string m);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk_i);
    penable <= 1;
    @(posedge mclk_i);
    while (pready !== 1'b1) @(posedge mclk_i);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(negedge mclk_i); // Let registered outputs settle before checks
  endtask
  // Two-cycle cause pulse, then time for sync and flag flops to land
  task automatic pulse(input logic [3:0] a, input logic [3:0] c,
                       input logic [7:0] f);
    @(posedge mclk_i);
    alm <= a; ca <= c; fifo <= f;
    repeat (2) @(posedge mclk_i);
    alm <= 0; ca <= 0; fifo <= 0;
    repeat (6) @(posedge mclk_i);
  endtask
  // Reset values and link held down while disabled
  task automatic t_reset;
    apb(0, OFS_MASK, 0); chk(rd, 32'h3f, "mask reset");
    apb(0, OFS_CTRL, 0); chk(rd, 32'h0, "ctrl reset");
    chk({lnk, lrst_n, pwrdn, gate}, 4'b0010, "link down");
  endtask
  // Each of the four cause inputs sets its own sticky flag; writing 0 keeps, 1 clears
  task automatic t_flags;
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i, 4'h0, 8'h00);
      apb(1, OFS_FLAGS, 0);
      apb(0, OFS_FLAGS, 0); chk(rd, 32'h1 << i, "flag set");
      chk(rd[i], 1'b1, "flag sticky");
      apb(1, OFS_FLAGS, 32'h1 << i);
      apb(0, OFS_FLAGS, 0); chk(rd, 32'h0, "flag clear");
    end
  endtask
  // Mask gates the summary; pin follows summary when selected
  task automatic t_mask;
    apb(1, OFS_MASK, 0); apb(1, OFS_CTRL, 32'h2);
    pulse(4'h2, 4'h0, 8'h00);
    chk(summ, 1'b1, "summary unmasked");
    chk(pin, 1'b1, "pin high");
    apb(0, OFS_SUMMARY, 0); chk(rd, 32'h1, "summary reg");
    apb(1, OFS_MASK, 32'h2);
    repeat (2) @(posedge mclk_i);
    chk(summ, 1'b0, "summary masked");
    chk(pin, 1'b0, "pin low");
    apb(1, OFS_FLAGS, 32'h2); apb(1, OFS_MASK, 0);
  endtask
  // One half-rate cycle of channel mismatch sets the clock upset flag
  task automatic t_clk;
    apb(1, OFS_CTRL, 32'h2); apb(1, OFS_CTRL, 32'h3);
    apb(1, OFS_FLAGS, 32'h10);
    pulse(4'h0, 4'h4, 8'h00);
    apb(0, OFS_FLAGS, 0); chk(rd, 32'h10, "clock upset");
    repeat (10) @(posedge mclk_i);
    apb(0, OFS_FLAGS, 0); chk(rd, 32'h10, "upset holds");
    chk(pin, 1'b1, "pin on upset");
    apb(1, OFS_FLAGS, 32'h10);
    apb(0, OFS_FLAGS, 0); chk(rd, 32'h0, "upset cleared");
  endtask
  // Lane upsets ignored while link is off, flagged while on
  task automatic t_lane;
    apb(1, OFS_CTRL, 32'h2);
    pulse(4'h0, 4'h0, 8'h80);
    apb(0, OFS_LANE, 0); chk(rd, 32'h0, "lane off");
    apb(1, OFS_CTRL, 32'h3);
    chk({lrst_n, pwrdn, gate}, 3'b101, "link up");
    pulse(4'h0, 4'h0, 8'h81);
    apb(0, OFS_LANE, 0); chk(rd, 32'h81, "lane flags");
    apb(0, OFS_FLAGS, 0); chk(rd, 32'h20, "lane summary bit");
    apb(1, OFS_CTRL, 32'h2);
    chk(lrst_n, 1'b0, "fifo reset");
    apb(1, OFS_LANE, 32'hff); apb(1, OFS_FLAGS, 32'h20);
    apb(0, OFS_LANE, 0); chk(rd, 32'h0, "lane clear");
  endtask
  // Interrupt raised, masked by enable, cleared by write-one
  task automatic t_irq;
    apb(1, OFS_IRQ_EN, 32'h1);
    pulse(4'h1, 4'h0, 8'h00);
    chk(irq, 1'b1, "irq high");
    apb(0, OFS_IRQ_ST, 0); chk(rd[0], 1'b1, "irq status");
    apb(1, OFS_IRQ_EN, 0); chk(irq, 1'b0, "irq disabled");
    apb(1, OFS_IRQ_EN, 32'h1); chk(irq, 1'b1, "irq re-enabled");
    apb(1, OFS_IRQ_CLR, 32'h1); apb(1, OFS_FLAGS, 32'h1);
    chk(irq, 1'b0, "irq cleared");
    apb(1, 8'h40, 32'hff); chk(err, 1'b1, "unmapped write");
    apb(0, 8'h40, 0); chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
  endtask
  // Mid-run reset as a wake from power-down; host clears upset flag
  task automatic t_rst2;
    apb(1, OFS_CTRL, 32'h3);
    @(posedge mclk_i); rstn_i <= 0;
    repeat (2) @(posedge mclk_i); rstn_i <= 1;
    apb(0, OFS_CTRL, 0); chk(rd, 32'h0, "ctrl after reset");
    pulse(4'h0, 4'h4, 8'h00);
    apb(1, OFS_FLAGS, 32'h10);
    apb(0, OFS_FLAGS, 0); chk(rd, 32'h0, "wake clear");
  endtask
  // Cuts a hang short; ceiling is far above the expected run
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1;
    t_reset(); t_flags(); t_mask(); t_clk(); t_lane(); t_irq();
    t_rst2();
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
